/* File: design/fcd_pkg.sv */
/*
   Shared constants for the flash command decoder: command bytes, command
   addresses, field positions, timing figures and reset values.
   Assumes a single 20 MHz clock domain for every file that imports it.
*/
package fcd_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLOCK_HZ           = 20_000_000;
   localparam int ERASE_WINDOW_US    = 80;
   // longest time: round down, never below one cycle
   localparam int ERASE_WINDOW_RAW   = (ERASE_WINDOW_US * (CLOCK_HZ / 1_000_000));
   localparam int ERASE_WINDOW_CYC   = (ERASE_WINDOW_RAW < 1) ? 1 : ERASE_WINDOW_RAW;
   localparam int CMD_TIMEOUT_DEF    = 2000;

   // ----------------------------------------------------------------
   // widths and field positions
   // ----------------------------------------------------------------
   localparam int ADDR_W             = 16;
   localparam int DATA_W             = 8;
   localparam int CMD_ADDR_W         = 12;
   localparam int MAIN_SEL_W         = 8;
   localparam int BOOT_SEL_W         = 4;
   localparam int SECT_W             = MAIN_SEL_W + BOOT_SEL_W;
   localparam int BIT_A0             = 0;
   localparam int BIT_A1             = 1;
   localparam int BIT_A6             = 6;

   // ----------------------------------------------------------------
   // command addresses and bytes
   // ----------------------------------------------------------------
   localparam logic [CMD_ADDR_W-1:0] ADDR_CODE1 = 12'h555;
   localparam logic [CMD_ADDR_W-1:0] ADDR_CODE2 = 12'hAAA;
   localparam logic [DATA_W-1:0] CMD_UNLOCK1    = 8'hAA;
   localparam logic [DATA_W-1:0] CMD_UNLOCK2    = 8'h55;
   localparam logic [DATA_W-1:0] CMD_PROGRAM    = 8'hA0;
   localparam logic [DATA_W-1:0] CMD_ERASE_SET  = 8'h80;
   localparam logic [DATA_W-1:0] CMD_SECT_ERASE = 8'h30;
   localparam logic [DATA_W-1:0] CMD_BULK_ERASE = 8'h10;
   localparam logic [DATA_W-1:0] CMD_IDENT      = 8'h90;
   localparam logic [DATA_W-1:0] CMD_BYPASS     = 8'h20;
   localparam logic [DATA_W-1:0] CMD_BYP_EXIT   = 8'h00;
   localparam logic [DATA_W-1:0] CMD_SUSPEND    = 8'hB0;
   localparam logic [DATA_W-1:0] CMD_RESET      = 8'hF0;

   // ----------------------------------------------------------------
   // read answers and reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] PROT_YES       = 8'h01;
   localparam logic [DATA_W-1:0] PROT_NO        = 8'h00;
   localparam logic [DATA_W-1:0] DEVICE_ID_DEF  = 8'h5A;  // arbitrary
   localparam logic [DATA_W-1:0] DATA_RST       = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST       = 16'h0000;
   localparam logic [SECT_W-1:0] SECT_RST       = 12'h000;

   // ----------------------------------------------------------------
   // decoder states
   // ----------------------------------------------------------------
   typedef enum logic [11:0] {
      FCD_READ      = 12'b0000_0000_0001,
      FCD_UNLK1     = 12'b0000_0000_0010,
      FCD_UNLK2     = 12'b0000_0000_0100,
      FCD_PROG      = 12'b0000_0000_1000,
      FCD_ERS3      = 12'b0000_0001_0000,
      FCD_ERS4      = 12'b0000_0010_0000,
      FCD_ERS5      = 12'b0000_0100_0000,
      FCD_ERS_MORE  = 12'b0000_1000_0000,
      FCD_AUTOSEL   = 12'b0001_0000_0000,
      FCD_BYP       = 12'b0010_0000_0000,
      FCD_BYP_PROG  = 12'b0100_0000_0000,
      FCD_BYP_RST   = 12'b1000_0000_0000
   } fcd_state_t;

endpackage

/* File: design/fcd_sync.sv */
/*
   Two flip-flop synchroniser for a bus of pin inputs.
   Assumes the inputs are asynchronous to clock; bus members are not
   guaranteed to resolve in the same cycle, so callers sample settled data.
*/
module fcd_sync
   import fcd_pkg::*;
#(
   parameter int                WIDTH = 1,
   parameter logic [WIDTH-1:0]  INIT  = '0
)(
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // meta feeds only q
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta <= INIT;
         q    <= INIT;
      end
      else if (ce)
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

/* File: design/fcd_timer.sv */
/*
   One-shot down counter: start loads the period, expired pulses one
   cycle when it runs out, stop abandons it.
   Assumes start and stop come from logic on the same clock.
*/
module fcd_timer
   import fcd_pkg::*;
#(
   parameter int CYCLES = 16
)(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic start,
   input  wire logic stop,
   output logic      expired
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
   localparam logic [CW-1:0] ZERO = '0;

   logic [CW-1:0] count;
   logic          running;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         count   <= ZERO;
         running <= 1'b0;
         expired <= 1'b0;
      end
      else if (ce)
      begin
         expired <= 1'b0;
         if (start)
         begin
            count   <= LOAD;
            running <= 1'b1;
         end
         else if (stop)
            running <= 1'b0;
         else if (running)
         begin
            if (count == ZERO)
            begin
               running <= 1'b0;
               expired <= 1'b1;
            end
            else
               count <= count - CW'(1);
         end
      end
   end

endmodule

/* File: design/fcd_decoder.sv */
/*
   Flash command decoder: watches the microcontroller bus, walks the
   multi-cycle command sequences and launches program, erase, suspend and
   resume operations towards the embedded algorithm engine; answers reads
   with array data, identifier or protection status.
   Assumes the engine sits on the same clock and reports busy, failure,
   erase-in-progress, array read data and protection of the selected sector.
*/
// Notes on behaviour
// - commands open with AA@555 then 55@AAA
// - only low twelve address bits compared
// - main or boot array chosen by selects
// - bytes decoded in sequence, gaps timed
// - bad byte or timeout returns read mode, or bypass mode while in bypass
// - read mode returns array data directly
// - F0 at even address resets to read; in bypass mode the code stays in bypass instead
// - address on strobe fall, data on rise
// - protect read at A1A0=10 gives 01/00
// - more 30h sectors accepted within 80us
// - bypass entry 20h, then two-write program
// - bypass exit with 90h then 00h
// - B0 suspends only a running sector erase
// - 30h resumes only a suspended erase
// - read mode after power-up
// - writes blocked below lockout threshold
// - erase sequence, sector or bulk sixth write
// - identifier read at A6A1A0=001, main array
// - byte program: A0 then data write
// - ready/busy low while program or erase
// - program to protected sector is discarded
// - reset command clears error flag
module fcd_decoder
   import fcd_pkg::*;
#(
   parameter int                CMD_TIMEOUT_CYCLES = CMD_TIMEOUT_DEF,
   parameter logic [DATA_W-1:0] DEVICE_ID          = DEVICE_ID_DEF  // arbitrary value
)(
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  wr_n,
   input  wire logic                  rd_n,
   input  wire logic [ADDR_W-1:0]     addr,
   input  wire logic [DATA_W-1:0]     data_in,
   input  wire logic [MAIN_SEL_W-1:0] main_sector_selects,
   input  wire logic [BOOT_SEL_W-1:0] boot_sector_selects,
   input  wire logic                  supply_low,
   input  wire logic                  engine_busy,
   input  wire logic                  engine_fail,
   input  wire logic                  erase_running,
   input  wire logic                  sector_protected,
   input  wire logic [DATA_W-1:0]     array_data,
   output logic      [DATA_W-1:0]     data_out,
   output logic                       data_oe_n,
   output logic                       ready_busy_pin,
   output logic                       error_flag_bit,
   output logic                       op_program,
   output logic                       op_sector_erase,
   output logic                       op_bulk_erase,
   output logic                       op_suspend,
   output logic                       op_resume,
   output logic                       op_target_boot,
   output logic      [ADDR_W-1:0]     op_address,
   output logic      [DATA_W-1:0]     op_data,
   output logic      [SECT_W-1:0]     erase_sectors
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic cmd_at(input logic [ADDR_W-1:0]     a,
                                   input logic [DATA_W-1:0]     d,
                                   input logic [CMD_ADDR_W-1:0] ea,
                                   input logic [DATA_W-1:0]     ed);
      cmd_at = (a[CMD_ADDR_W-1:0] == ea) && (d == ed);
   endfunction

   function automatic logic cmd_even(input logic [ADDR_W-1:0] a,
                                     input logic [DATA_W-1:0] d,
                                     input logic [DATA_W-1:0] ed);
      cmd_even = !a[BIT_A0] && (d == ed);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int PIN_W = 2 + ADDR_W + DATA_W + SECT_W + 1;

   logic [PIN_W-1:0] pins_s;
   logic             wr_s;
   logic             rd_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic [SECT_W-1:0] sel_s;
   logic             low_s;

   // strobes idle high so no false edge at release
   fcd_sync #(
      .WIDTH (PIN_W),
      .INIT  ({2'b11, {(PIN_W-2){1'b0}}})
   ) u_sync (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .d     ({wr_n, rd_n, addr, data_in, boot_sector_selects, main_sector_selects,
               supply_low}),
      .q     (pins_s)
   );

   assign {wr_s, rd_s, addr_s, data_s, sel_s, low_s} = pins_s;

   // ----------------------------------------------------------------
   // strobe edges and latches
   // ----------------------------------------------------------------
   logic             wr_d;
   logic             wr_active;
   logic [ADDR_W-1:0] lat_addr;
   logic [SECT_W-1:0] lat_sel;
   logic             wr_fall;
   logic             wr_rise;
   logic             commit;
   logic             lat_main;
   logic             lat_boot;

   assign wr_fall  = wr_d && !wr_s;
   assign wr_rise  = !wr_d && wr_s;
   assign lat_main = |lat_sel[MAIN_SEL_W-1:0];
   assign lat_boot = |lat_sel[SECT_W-1:MAIN_SEL_W];

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wr_d      <= 1'b1;
         wr_active <= 1'b0;
         lat_addr  <= ADDR_RST;
         lat_sel   <= SECT_RST;
      end
      else if (ce)
      begin
         wr_d <= wr_s;
         if (wr_fall)
         begin
            // a cycle started under lockout is never armed
            wr_active <= !low_s;
            lat_addr  <= addr_s;
            lat_sel   <= sel_s;
         end
         else if (wr_rise)
            wr_active <= 1'b0;
      end
   end

   // unselected writes go to neither array
   logic sus;
   logic wr_ok;

   assign wr_ok  = !engine_busy || (erase_running && !sus && data_s == CMD_SUSPEND);
   assign commit = wr_rise && wr_active && (lat_main || lat_boot) && wr_ok;

   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   fcd_state_t state;
   fcd_state_t next_state;
   logic       cmd_expired;
   logic       win_expired;
   logic       win_start;
   logic       mid_seq;
   logic       in_byp;

   assign mid_seq = (state != FCD_READ) && (state != FCD_AUTOSEL) &&
                    (state != FCD_BYP) && (state != FCD_ERS_MORE);
   assign in_byp  = (state == FCD_BYP_PROG) || (state == FCD_BYP_RST);
   assign win_start = commit && data_s == CMD_SECT_ERASE &&
                      (state == FCD_ERS5 || state == FCD_ERS_MORE);

   fcd_timer #(
      .CYCLES (CMD_TIMEOUT_CYCLES)
   ) u_cmd_timer (
      .clock   (clock),
      .rst     (rst),
      .ce      (ce),
      .start   (commit),
      .stop    (!mid_seq),
      .expired (cmd_expired)
   );

   fcd_timer #(
      .CYCLES (ERASE_WINDOW_CYC)
   ) u_win_timer (
      .clock   (clock),
      .rst     (rst),
      .ce      (ce),
      .start   (win_start),
      .stop    (state != FCD_ERS_MORE),
      .expired (win_expired)
   );

   // ----------------------------------------------------------------
   // sequence decoder
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      if (commit)
      begin
         case (state)
            FCD_READ:
               if (cmd_at(lat_addr, data_s, ADDR_CODE1, CMD_UNLOCK1))
                  next_state = FCD_UNLK1;
            FCD_UNLK1:
               if (cmd_at(lat_addr, data_s, ADDR_CODE2, CMD_UNLOCK2))
                  next_state = FCD_UNLK2;
               else
                  next_state = FCD_READ;
            FCD_UNLK2:
               if (cmd_at(lat_addr, data_s, ADDR_CODE1, CMD_PROGRAM))
                  next_state = FCD_PROG;
               else if (cmd_at(lat_addr, data_s, ADDR_CODE1, CMD_ERASE_SET) && !sus)
                  next_state = FCD_ERS3;
               else if (cmd_at(lat_addr, data_s, ADDR_CODE1, CMD_IDENT))
                  next_state = FCD_AUTOSEL;
               else if (cmd_at(lat_addr, data_s, ADDR_CODE1, CMD_BYPASS) && !sus)
                  next_state = FCD_BYP;
               else
                  next_state = FCD_READ;
            FCD_PROG:
               next_state = FCD_READ;
            FCD_ERS3:
               next_state = cmd_at(lat_addr, data_s, ADDR_CODE2, CMD_UNLOCK1) ?
                            FCD_ERS4 : FCD_READ;
            FCD_ERS4:
               next_state = cmd_at(lat_addr, data_s, ADDR_CODE2, CMD_UNLOCK2) ?
                            FCD_ERS5 : FCD_READ;
            FCD_ERS5:
               if (data_s == CMD_SECT_ERASE)
                  next_state = FCD_ERS_MORE;
               else
                  next_state = FCD_READ;
            FCD_ERS_MORE:
               if (data_s != CMD_SECT_ERASE)
                  next_state = FCD_READ;
            FCD_AUTOSEL:
               if (cmd_even(lat_addr, data_s, CMD_RESET))
                  next_state = FCD_READ;
            FCD_BYP:
               if (cmd_even(lat_addr, data_s, CMD_PROGRAM))
                  next_state = FCD_BYP_PROG;
               else if (cmd_even(lat_addr, data_s, CMD_IDENT))
                  next_state = FCD_BYP_RST;
            FCD_BYP_PROG:
               next_state = FCD_BYP;
            FCD_BYP_RST:
               next_state = cmd_even(lat_addr, data_s, CMD_BYP_EXIT) ?
                            FCD_READ : FCD_BYP;
            default:
               next_state = FCD_READ;
         endcase
         // reset works in any cycle except the program data cycle and bypass mode
         if (cmd_even(lat_addr, data_s, CMD_RESET) && !in_byp && state != FCD_PROG &&
             state != FCD_BYP)
            next_state = FCD_READ;
      end
      else if (cmd_expired && mid_seq)
         next_state = in_byp ? FCD_BYP : FCD_READ;
      else if (win_expired)
         next_state = FCD_READ;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state <= FCD_READ;
      else if (ce)
         state <= next_state;
   end

   // ----------------------------------------------------------------
   // operation launch
   // ----------------------------------------------------------------
   logic prog_cycle;
   logic ers_done;
   logic reset_cmd;

   assign prog_cycle = commit && (state == FCD_PROG || state == FCD_BYP_PROG);
   assign ers_done   = (state == FCD_ERS_MORE) &&
                       (win_expired || (commit && data_s != CMD_SECT_ERASE));
   assign reset_cmd  = commit && next_state == FCD_READ &&
                       cmd_even(lat_addr, data_s, CMD_RESET);

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         op_program      <= 1'b0;
         op_sector_erase <= 1'b0;
         op_bulk_erase   <= 1'b0;
         op_suspend      <= 1'b0;
         op_resume       <= 1'b0;
         op_target_boot  <= 1'b0;
         op_address      <= ADDR_RST;
         op_data         <= DATA_RST;
         erase_sectors   <= SECT_RST;
         sus             <= 1'b0;
      end
      else if (ce)
      begin
         op_program      <= 1'b0;
         op_sector_erase <= 1'b0;
         op_bulk_erase   <= 1'b0;
         op_suspend      <= 1'b0;
         op_resume       <= 1'b0;
         if (commit)
            op_target_boot <= !lat_main;
         if (prog_cycle)
         begin
            op_address <= lat_addr;
            op_data    <= data_s;
            op_program <= !sector_protected;
         end
         if (commit && state == FCD_ERS5)
         begin
            if (data_s == CMD_SECT_ERASE)
               erase_sectors <= lat_sel;
            else if (cmd_at(lat_addr, data_s, ADDR_CODE1, CMD_BULK_ERASE))
               op_bulk_erase <= 1'b1;
         end
         if (win_start && state == FCD_ERS_MORE)
            erase_sectors <= erase_sectors | lat_sel;
         if (ers_done)
            op_sector_erase <= 1'b1;
         if (commit && state == FCD_READ)
         begin
            if (data_s == CMD_SUSPEND && erase_running && !sus)
            begin
               op_suspend <= 1'b1;
               sus        <= 1'b1;
            end
            else if (cmd_even(lat_addr, data_s, CMD_SECT_ERASE) && sus)
            begin
               op_resume <= 1'b1;
               sus       <= 1'b0;
            end
         end
         if (reset_cmd && state == FCD_READ && !erase_running)
            sus <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // status pins
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ready_busy_pin <= 1'b1;
         error_flag_bit <= 1'b0;
      end
      else if (ce)
      begin
         // program, erase and resume launch pulses count as busy before the engine answers
         ready_busy_pin <= !(engine_busy || op_program || op_sector_erase ||
                             op_bulk_erase || op_resume);
         // a failure in the same cycle beats the clear
         if (engine_fail)
            error_flag_bit <= 1'b1;
         else if (reset_cmd)
            error_flag_bit <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic rd_main;
   logic rd_any;

   assign rd_main = |sel_s[MAIN_SEL_W-1:0];
   assign rd_any  = rd_main || (|sel_s[SECT_W-1:MAIN_SEL_W]);

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         data_out  <= DATA_RST;
         data_oe_n <= 1'b1;
      end
      else if (ce)
      begin
         data_oe_n <= !(!rd_s && rd_any);
         if (state == FCD_AUTOSEL && addr_s[BIT_A1] && !addr_s[BIT_A0])
            data_out <= sector_protected ? PROT_YES : PROT_NO;
         else if (state == FCD_AUTOSEL && rd_main && !addr_s[BIT_A6] &&
                  !addr_s[BIT_A1] && addr_s[BIT_A0])
            data_out <= DEVICE_ID;
         else
            data_out <= array_data;
      end
   end

endmodule

/* File: tb/fcd_decoder_props.sv */
/* Port checker for fcd_decoder.
   Assumes the bind below and one clock domain. */
module fcd_props
   import fcd_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  rst,
   input wire logic                  rd_n,
   input wire logic [DATA_W-1:0]     data_in,
   input wire logic                  engine_busy,
   input wire logic                  engine_fail,
   input wire logic                  ready_busy_pin,
   input wire logic                  error_flag_bit,
   input wire logic                  data_oe_n,
   input wire logic                  op_program,
   input wire logic                  op_sector_erase,
   input wire logic                  op_bulk_erase,
   input wire logic                  op_suspend,
   input wire logic                  op_resume
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------
   // properties
   // ---------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_LAUNCH_BUSY: assert property (op_program || op_bulk_erase |=> !ready_busy_pin)
      else $error("busy not shown after launch");
   AST_ENGINE_BUSY: assert property (engine_busy |=> !ready_busy_pin)
      else $error("busy not shown for engine");
   AST_IDLE_READY: assert property (!engine_busy && !op_program && !op_sector_erase
      && !op_bulk_erase && !op_suspend && !op_resume |=> ready_busy_pin)
      else $error("ready missing when idle");
   AST_ONE_OP: assert property ($onehot0({op_program, op_sector_erase, op_bulk_erase,
      op_suspend, op_resume})) else $error("two launches at once");
   AST_PROG_PULSE: assert property (op_program |=> !op_program)
      else $error("program launch too long");
   AST_BULK_PULSE: assert property (op_bulk_erase |=> !op_bulk_erase)
      else $error("bulk launch too long");
   AST_ERR_SET: assert property (engine_fail |=> error_flag_bit)
      else $error("error flag not set");
   AST_ERR_CLEAR: assert property ($fell(error_flag_bit) |-> $past(data_in, 3) == CMD_RESET)
      else $error("error flag cleared without reset byte");
   AST_OE_READ: assert property (!data_oe_n |-> !$past(rd_n, 3))
      else $error("data driven without read");
endmodule
bind fcd_decoder fcd_props i_props(.clock, .rst, .rd_n, .data_in, .engine_busy, .engine_fail,
   .ready_busy_pin, .error_flag_bit, .data_oe_n, .op_program, .op_sector_erase,
   .op_bulk_erase, .op_suspend, .op_resume);

/* File: tb/fcd_host_model.sv */
/* Microcontroller bus model: slow strobes, addresses as given.
   Assumes the decoder answers reads within five cycles. */
module fcd_host_model
   import fcd_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic [DATA_W-1:0]     data_out,
   output logic                       wr_n,
   output logic                       rd_n,
   output logic      [ADDR_W-1:0]     addr,
   output logic      [DATA_W-1:0]     data_in,
   output logic      [MAIN_SEL_W-1:0] main_sector_selects
);
   // ---------------------------
   // bus cycles
   // ---------------------------
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      wr_n = 1'b1;
      rd_n = 1'b1;
      addr = 16'h0000;
      data_in = 8'h00;
      main_sector_selects = 8'h00;
   end
   // strobe held four cycles: the synchroniser has two stages
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      addr <= a;
      data_in <= d;
      main_sector_selects <= 8'h01;
      wr_n <= 1'b0;
      repeat (4) @(posedge clock);
      wr_n <= 1'b1;
      repeat (4) @(posedge clock);
      data_in <= ~d; // released bus must not look held
      main_sector_selects <= 8'h00;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
      @(posedge clock);
      addr <= a;
      main_sector_selects <= 8'h01;
      rd_n <= 1'b0;
      repeat (5) @(posedge clock);
      q = data_out;
      rd_n <= 1'b1;
      main_sector_selects <= 8'h00;
      repeat (4) @(posedge clock);
   endtask
endmodule

/* File: tb/tb.sv */
/* Self-checking bench for fcd_decoder.
   Assumes the host model and the bound checker. */
module tb
   import fcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------
   // harness
   // ---------------------------
   localparam int TMO = 50;
   logic              clock = 1'b0;
   logic              rst = 1'b1;
   logic              wr_n, rd_n, oe_n, rdy, err, op_program, op_bulk, fail, prot;
   logic [ADDR_W-1:0] addr, op_address;
   logic [DATA_W-1:0] d_in, d_out, op_data, arr, q;
   logic [7:0]        sel;
   int                n_fail, samples_checked, cycles, n_prog, n_bulk;
   always #25 clock = ~clock;
   fcd_host_model i_host(.clock, .data_out(d_out), .wr_n, .rd_n, .addr, .data_in(d_in),
      .main_sector_selects(sel));
   fcd_decoder #(.CMD_TIMEOUT_CYCLES(TMO)) i_dut(.clock, .rst, .ce(1'b1), .wr_n, .rd_n,
      .addr, .data_in(d_in), .main_sector_selects(sel), .boot_sector_selects(4'h0),
      .supply_low(1'b0), .engine_busy(1'b0), .engine_fail(fail), .erase_running(1'b0),
      .sector_protected(prot), .array_data(arr), .data_out(d_out), .data_oe_n(oe_n),
      .ready_busy_pin(rdy), .error_flag_bit(err), .op_program, .op_sector_erase(),
      .op_bulk_erase(op_bulk), .op_suspend(), .op_resume(), .op_target_boot(),
      .op_address, .op_data, .erase_sectors());
   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clock)
   begin
      n_prog += (op_program === 1'b1);
      n_bulk += (op_bulk === 1'b1);
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   // upper address bits set: must be ignored
   task automatic unlock(input logic [DATA_W-1:0] c);
      i_host.wr(16'hF555, CMD_UNLOCK1);
      i_host.wr(16'hFAAA, CMD_UNLOCK2);
      i_host.wr(16'hF555, c);
   endtask
   task automatic t_prog(input logic p, input int n);
      prot <= p;
      unlock(CMD_PROGRAM);
      i_host.wr(16'h2468, 8'h5B);
      repeat (4) @(posedge clock);
      prot <= 1'b0;
      check("programs", 16'(n), 16'(n_prog));
      check("address", 16'h2468, op_address);
      check("data", 16'h005B, 16'(op_data));
      $display("test program done");
   endtask
   task automatic t_abort();
      unlock(8'h77);
      i_host.wr(16'h0555, CMD_PROGRAM);
      i_host.wr(16'h3000, 8'h11);
      i_host.wr(16'h0555, CMD_UNLOCK1);
      repeat (TMO + 10) @(posedge clock);
      i_host.wr(16'h0AAA, CMD_UNLOCK2);
      i_host.wr(16'h0555, CMD_PROGRAM);
      i_host.wr(16'h3002, 8'h22);
      repeat (4) @(posedge clock);
      check("aborted", 16'd1, 16'(n_prog));
      $display("test abort done");
   endtask
   task automatic t_erase_err();
      unlock(CMD_ERASE_SET);
      i_host.wr(16'h0AAA, CMD_UNLOCK1);
      i_host.wr(16'h0AAA, CMD_UNLOCK2);
      i_host.wr(16'h0555, CMD_BULK_ERASE);
      repeat (4) @(posedge clock);
      check("bulk", 16'd1, 16'(n_bulk));
      fail <= 1'b1;
      @(posedge clock);
      fail <= 1'b0;
      repeat (2) @(posedge clock);
      check("err set", 16'd1, 16'(err));
      i_host.wr(16'h0002, CMD_RESET);
      repeat (4) @(posedge clock);
      check("err clear", 16'd0, 16'(err));
      $display("test erase done");
   endtask
   task automatic t_ident();
      unlock(CMD_IDENT);
      i_host.rd(16'h0001, q);
      check("ident", 16'(DEVICE_ID_DEF), 16'(q));
      prot <= 1'b1;
      i_host.rd(16'h0002, q);
      check("protected", 16'(PROT_YES), 16'(q));
      prot <= 1'b0;
      i_host.rd(16'h0002, q);
      check("open", 16'(PROT_NO), 16'(q));
      i_host.wr(16'h0000, CMD_RESET);
      i_host.rd(16'h1234, q);
      check("array", 16'h003C, 16'(q));
      $display("test ident done");
   endtask
   task automatic t_bypass();
      unlock(CMD_BYPASS);
      i_host.wr(16'h0000, CMD_PROGRAM);
      i_host.wr(16'h1356, 8'h6C);
      i_host.wr(16'h0000, CMD_IDENT);
      i_host.wr(16'h0000, CMD_BYP_EXIT);
      t_prog(1'b0, 3);
   endtask
   initial
   begin
      fail = 1'b0;
      prot = 1'b0;
      arr = 8'h3C;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      t_prog(1'b0, 1);
      t_prog(1'b1, 1);
      t_abort();
      t_erase_err();
      t_ident();
      t_bypass();
      give_verdict();
   end
endmodule
